// *** core/mdc_arith_coprocessor.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mdc_regs.svh"
// Notes on behaviour
// [RQ1] multiply 16x16 to 32 in one cycle
// [RQ2] signed MAC into result, flag overflow
// [RQ3] divide 16/16, quotient and residue, 17-20 cycles
// [RQ4] core writes 7-bit mode, latched here
// [RQ5] mode from rs[6:0], rd ignored
// [RQ6] output select 0 low, 1 high
// [RQ7] return only selected 16-bit half
// [RQ8] op 0 clears result register
// [RQ9] op 1 loads 16-bit low half
// [RQ10] op 2 loads full 32-bit value
// [RQ11] op 3 reads result unchanged
// [RQ12] decode 4,5,8,9 as mul/div ops
// [RQ13] op 7 signed MAC; others reserved
// [RQ14] clear happens on the mode write itself
// [RQ15] quotient low half, residue high half
// [RQ16] reserved codes: result kept, zero returned
// [RQ17] stall core during division until ready
module mdc_arith_coprocessor (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // transfer strobes from core
  input wire logic mode_write_transfer_i,
  input wire logic operand_compute_transfer_i,
  input wire logic initial_value_transfer_i,
  input wire mdc_pkg::mdc_opnd_t opnd_i,
  // answer to core
  output logic stall_o,
  output logic [15:0] result_o,
  output mdc_pkg::mdc_flags_t flags_o,
  output logic [`MDC_MODE_W-1:0] mode_o
);
  import mdc_pkg::*;

  // mode register: output select in the upper bits, operation code below
  logic [`MDC_MODE_W-1:0] operation_output_select_ff;

  // 32-bit result register shared by all operations
  logic [31:0] res_ff;
  logic [31:0] nxt_res;
  logic nxt_res_we;
  logic [3:0] op;
  logic [2:0] osel;
  logic [31:0] prod_u;
  logic [31:0] prod_s;
  logic [32:0] mac_sum;
  logic mac_ovf;

  // divider handshake
  logic div_busy;
  logic div_done;
  logic div_pend_ff;
  logic [15:0] quot;
  logic [15:0] rem;
  logic div_start;

  // pick the 16-bit half named by the output select; reserved selects give zero
  function automatic logic [15:0] pick_half(input logic [2:0] sel,
      input logic [31:0] v);
    unique case (sel)
      `MDC_OUT_LO: pick_half = v[15:0]; // RQ6
      `MDC_OUT_HI: pick_half = v[31:16]; // RQ6
      default: pick_half = 16'h0000; // RQ16
    endcase
  endfunction

  // operation codes that start the iterative divider
  function automatic logic is_div_op(input logic [3:0] code);
    is_div_op = (code == `MDC_OP_UDIV) | (code == `MDC_OP_SDIV);
  endfunction

  // operation code in the low bits, output select in the high bits
  assign op = operation_output_select_ff[`MDC_OP_MSB:0];
  assign osel = operation_output_select_ff[`MDC_OUT_MSB:`MDC_OUT_LSB];
  assign mode_o = operation_output_select_ff;
  // one-cycle products of the current operands
  assign prod_u = opnd_i.rd * opnd_i.rs; // RQ1
  // sign-extend both operands first: a cast around a 16-bit product keeps 16 bits only
  assign prod_s = {{16{opnd_i.rd[15]}}, opnd_i.rd} * {{16{opnd_i.rs[15]}}, opnd_i.rs}; // RQ1
  // MAC sum carries one guard bit; overflow when the two top bits differ
  assign mac_sum = {res_ff[31], res_ff} + {prod_s[31], prod_s}; // RQ2
  assign mac_ovf = mac_sum[32] ^ mac_sum[31]; // RQ2
  // a new divide is only taken while no earlier one is pending
  assign div_start = operand_compute_transfer_i & ~div_busy & ~div_pend_ff
    & is_div_op(op); // RQ12

  // mode word; rd is not used, only the low bits of rs are kept
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      operation_output_select_ff <= `MDC_MODE_RST;
    end else if (mode_write_transfer_i) begin
      operation_output_select_ff <= opnd_i.rs[`MDC_MODE_W-1:0]; // RQ4 RQ5
    end
  end

  // next result register value, one source per cycle:
  // - a mode write that selects op 0 clears at once, without a data transfer
  // - a finished divide lands quotient and residue
  // - an initial value transfer loads in the load modes only
  // - a compute transfer updates for multiply and MAC only
  // read mode and reserved codes leave the register as it is
  always_comb begin
    nxt_res = res_ff;
    nxt_res_we = 1'b0;
    if (mode_write_transfer_i) begin
      if (opnd_i.rs[`MDC_OP_MSB:0] == `MDC_OP_CLR) begin
        nxt_res = `MDC_RES_RST; // RQ8 RQ14
        nxt_res_we = 1'b1;
      end
    end else if (div_done) begin
      nxt_res = {rem, quot}; // RQ15
      nxt_res_we = 1'b1;
    end else if (initial_value_transfer_i) begin
      if (op == `MDC_OP_LD16) begin
        nxt_res = {16'h0000, opnd_i.rs}; // RQ9
        nxt_res_we = 1'b1;
      end else if (op == `MDC_OP_LD32) begin
        nxt_res = {opnd_i.rd, opnd_i.rs}; // RQ10
        nxt_res_we = 1'b1;
      end
    end else if (operand_compute_transfer_i) begin
      unique case (op)
        `MDC_OP_UMUL: begin
          nxt_res = prod_u; // RQ12
          nxt_res_we = 1'b1;
        end
        `MDC_OP_SMUL: begin
          nxt_res = prod_s; // RQ12
          nxt_res_we = 1'b1;
        end
        `MDC_OP_SMAC: begin
          nxt_res = mac_sum[31:0]; // RQ13 RQ2
          nxt_res_we = 1'b1;
        end
        default: nxt_res_we = 1'b0; // RQ11 RQ16
      endcase
    end
  end

  // result register keeps its value until one of the sources above writes it
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      res_ff <= `MDC_RES_RST;
    end else if (nxt_res_we) begin
      res_ff <= nxt_res;
    end
  end

  // division handshake: hold stall from transfer until quotient lands
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      div_pend_ff <= 1'b0;
    end else if (div_start) begin
      div_pend_ff <= 1'b1;
    end else if (div_done) begin
      div_pend_ff <= 1'b0;
    end
  end
  // stall is combinational so the core sees it in the very cycle of its transfer;
  // it drops in the cycle the divider reports done, when the answer is registered
  assign stall_o = div_start | (div_pend_ff & ~div_done); // RQ17 RQ3

  // answer: computed half of the new result, registered for the core
  // the core reads result_o one cycle after its transfer; flags are zero except
  // MAC overflow, and a transfer refused during a divide changes nothing
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      result_o <= 16'h0000;
      flags_o <= '0;
    end else if (div_done) begin
      result_o <= pick_half(osel, {rem, quot}); // RQ7 RQ15
      flags_o <= '0;
    end else if (operand_compute_transfer_i & ~div_start & ~div_pend_ff) begin
      flags_o <= '0;
      unique case (op)
        `MDC_OP_UMUL, `MDC_OP_SMUL: begin
          result_o <= pick_half(osel, nxt_res); // RQ7
        end
        `MDC_OP_SMAC: begin
          result_o <= pick_half(osel, nxt_res); // RQ7
          flags_o.v <= mac_ovf; // RQ2
        end
        `MDC_OP_CLR, `MDC_OP_LD16, `MDC_OP_LD32, `MDC_OP_READ: begin
          result_o <= pick_half(osel, res_ff); // RQ11
        end
        default: result_o <= 16'h0000; // RQ16
      endcase
    end
  end

  // the divider latches its operands on start, so the core may change them
  // while it waits out the stall
  mdc_divider #(
    .W(16)
  ) u_div (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .start_i(div_start),
    .signed_i(op == `MDC_OP_SDIV),
    .dividend_i(opnd_i.rd),
    .divisor_i(opnd_i.rs),
    .busy_o(div_busy),
    .done_o(div_done),
    .quot_o(quot),
    .rem_o(rem)
  ); // RQ3
endmodule
`default_nettype wire

// *** core/mdc_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mdc_regs.svh"
// iterative restoring divider: 1 load + 1 prep + 16 steps + 1 fix = 19 cycles to done
module mdc_divider #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // request
  input wire logic start_i,
  input wire logic signed_i,
  input wire logic [W-1:0] dividend_i,
  input wire logic [W-1:0] divisor_i,
  // answer
  output logic busy_o,
  output logic done_o,
  output logic [W-1:0] quot_o,
  output logic [W-1:0] rem_o
);
  import mdc_pkg::*;
  mdc_div_state_t state_ff;
  logic [W-1:0] q_ff;
  logic [W:0] r_ff;
  logic [W-1:0] d_ff;
  logic neg_q_ff;
  logic neg_r_ff;
  logic [4:0] cnt_ff;
  logic done_ff;
  logic [W:0] trial;
  assign trial = {r_ff[W-1:0], q_ff[W-1]} - {1'b0, d_ff};
  assign busy_o = (state_ff != MDC_IDLE);
  assign done_o = done_ff;
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state_ff <= MDC_IDLE;
      q_ff <= '0;
      r_ff <= '0;
      d_ff <= '0;
      neg_q_ff <= 1'b0;
      neg_r_ff <= 1'b0;
      cnt_ff <= '0;
      done_ff <= 1'b0;
      quot_o <= '0;
      rem_o <= '0;
    end else begin
      done_ff <= 1'b0;
      unique case (state_ff)
        MDC_IDLE: begin
          if (start_i) begin
            q_ff <= dividend_i;
            d_ff <= divisor_i;
            neg_q_ff <= signed_i & (dividend_i[W-1] ^ divisor_i[W-1]);
            neg_r_ff <= signed_i & dividend_i[W-1];
            state_ff <= MDC_PREP;
          end
        end
        MDC_PREP: begin
          // magnitudes for the signed case
          if (neg_r_ff) q_ff <= -q_ff;
          if (signed_i & d_ff[W-1]) d_ff <= -d_ff;
          r_ff <= '0;
          cnt_ff <= `MDC_DIV_STEPS;
          state_ff <= MDC_STEP;
        end
        MDC_STEP: begin
          if (!trial[W]) begin
            r_ff <= trial;
            q_ff <= {q_ff[W-2:0], 1'b1};
          end else begin
            r_ff <= {r_ff[W-1:0], q_ff[W-1]};
            q_ff <= {q_ff[W-2:0], 1'b0};
          end
          cnt_ff <= cnt_ff - 5'h01;
          if (cnt_ff == 5'h01) state_ff <= MDC_FIX;
        end
        MDC_FIX: begin
          quot_o <= neg_q_ff ? -q_ff : q_ff;
          rem_o <= neg_r_ff ? -r_ff[W-1:0] : r_ff[W-1:0];
          done_ff <= 1'b1;
          state_ff <= MDC_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** core/mdc_pkg.sv ***
package mdc_pkg;
  typedef struct packed {
    logic [15:0] rd;
    logic [15:0] rs;
  } mdc_opnd_t;
  typedef struct packed {
    logic c;
    logic v;
    logic z;
    logic n;
  } mdc_flags_t;
  typedef enum logic [1:0] {
    MDC_IDLE,
    MDC_PREP,
    MDC_STEP,
    MDC_FIX
  } mdc_div_state_t;
endpackage

// *** core/mdc_regs.svh ***
`ifndef MDC_REGS_SVH
`define MDC_REGS_SVH
`define MDC_MODE_W 7
`define MDC_MODE_RST 7'h00
`define MDC_OUT_LSB 4
`define MDC_OUT_MSB 6
`define MDC_OP_MSB 3
`define MDC_OUT_LO 3'h0
`define MDC_OUT_HI 3'h1
`define MDC_OP_CLR 4'h0
`define MDC_OP_LD16 4'h1
`define MDC_OP_LD32 4'h2
`define MDC_OP_READ 4'h3
`define MDC_OP_UMUL 4'h4
`define MDC_OP_SMUL 4'h5
`define MDC_OP_SMAC 4'h7
`define MDC_OP_UDIV 4'h8
`define MDC_OP_SDIV 4'h9
`define MDC_RES_RST 32'h0000_0000
`define MDC_DIV_STEPS 5'h10
`endif

// *** verif/mdc_arith_coprocessor_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module mdc_arith_coprocessor_tb_top;
  import mdc_pkg::*;
  logic sys_clk_i, reset_n_i, stall_o;
  logic [2:0] x;
  logic [15:0] result_o, r, a, b;
  logic [6:0] mode_o, m;
  logic [31:0] er, nr, p;
  mdc_opnd_t opnd;
  mdc_flags_t flags_o;
  int err_count, n_tests;
  mdc_arith_coprocessor mdc_arith_coprocessor_i (.sys_clk_i, .reset_n_i,
    .mode_write_transfer_i(x[2]), .operand_compute_transfer_i(x[1]),
    .initial_value_transfer_i(x[0]), .opnd_i(opnd), .stall_o, .result_o, .flags_o, .mode_o);
  mdc_core_model mdc_core_model_i (.clk_i(sys_clk_i), .stall_i(stall_o),
    .result_i(result_o), .xfer_o(x), .opnd_o(opnd));
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic conclude();
    if (err_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  function automatic logic [31:0] calc(input logic [3:0] op, input logic [31:0] e,
      input logic [15:0] u, input logic [15:0] v);
    case (op)
      4'h0: return 32'h0000_0000;
      4'h1: return {16'h0000, v};
      4'h2: return {u, v};
      4'h4: return u * v;
      4'h5: return $signed(u) * $signed(v);
      4'h7: return $signed(e) + $signed(u) * $signed(v);
      4'h8: return {u % v, u / v};
      4'h9: return {$signed(u) % $signed(v), $signed(u) / $signed(v)};
      default: return e;
    endcase
  endfunction
  function automatic logic [15:0] half(input logic [6:0] d, input logic [31:0] e);
    if (d[6:5] != 2'h0 || d[3:0] == 4'h6 || d[3:1] > 3'h4) return 16'h0000;
    return d[4] ? e[31:16] : e[15:0];
  endfunction
  initial begin
    #(40 * 40000);
    err_count++;
    conclude();
  end
  initial begin
    reset_n_i = 1'b0;
    err_count = 0;
    n_tests = 0;
    er = 32'h0000_0000;
    void'($urandom(32'hA3CE35D0));
    repeat (20) @(posedge sys_clk_i);
    #1 reset_n_i = 1'b1;
    check("res", result_o, 16'h0000);
    // every code with both halves first, then random modes
    for (int i = 0; i < 300; i++) begin
      m = i < 32 ? 7'(i) : {3'($urandom_range(2)), 4'($urandom)};
      a = 16'($urandom);
      b = 16'($urandom_range(65535, 1));
      mdc_core_model_i.xfer(3'h4, {16'($urandom), 9'($urandom), m}, r);
      check("mode", mode_o, m);
      if (m[3:0] inside {4'h1, 4'h2}) mdc_core_model_i.xfer(3'h1, {a, b}, r);
      nr = calc(m[3:0], er, a, b);
      p = nr - er;
      mdc_core_model_i.xfer(3'h2, {a, b}, r);
      check("res", r, half(m, nr));
      check("flg", flags_o, {1'b0, m[3:0] == 4'h7 && er[31] == p[31] && nr[31] != er[31],
        2'h0});
      er = nr;
    end
    conclude();
  end
endmodule
`default_nettype wire

// *** verif/mdc_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "mdc_regs.svh"
module mdc_checker (
  // requests
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic mode_write_transfer_i,
  input wire logic operand_compute_transfer_i,
  input wire mdc_pkg::mdc_opnd_t opnd_i,
  // answers
  input wire logic stall_o,
  input wire logic [15:0] result_o,
  input wire mdc_pkg::mdc_flags_t flags_o,
  input wire logic [`MDC_MODE_W-1:0] mode_o
);
  import mdc_pkg::*;
  logic [4:0] cnt_ff;
  logic cx;
  // an answering compute transfer
  assign cx = operand_compute_transfer_i && !mode_write_transfer_i && !stall_o;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i || !stall_o) cnt_ff <= 5'h00;
    else cnt_ff <= cnt_ff + 5'h01;
  end
  a_mode_latch: assert property (mode_write_transfer_i |=>
    mode_o == $past(opnd_i.rs[6:0])) else $error("mode lost");
  a_mode_hold: assert property (!mode_write_transfer_i |=> $stable(mode_o))
    else $error("mode drift");
  a_div_span: assert property ($fell(stall_o) |-> cnt_ff inside {[5'h11:5'h14]})
    else $error("div length");
  a_stall_cause: assert property ($rose(stall_o) |->
    operand_compute_transfer_i && mode_o[3:1] == 3'h4) else $error("bad stall");
  a_clear_read: assert property (cx && mode_o[3:0] == 4'h0 |=> result_o == 16'h0000)
    else $error("not clear");
  a_resv_zero: assert property (cx && (mode_o[6:5] != 2'h0 || mode_o[3:0] == 4'h6 ||
    mode_o[3:1] > 3'h4) |=> result_o == 16'h0000) else $error("reserved");
  a_mul_low: assert property (cx && mode_o[6:1] == 6'h02 |=> flags_o == 4'h0 &&
    result_o == 16'($past(opnd_i.rd) * $past(opnd_i.rs))) else $error("mul low");
  a_mul_high: assert property (cx && mode_o == 7'h14 |=> result_o ==
    16'(({16'h0000, $past(opnd_i.rd)} * {16'h0000, $past(opnd_i.rs)}) >> 16))
    else $error("mul high");
endmodule
bind mdc_arith_coprocessor mdc_checker mdc_checker_i (.sys_clk_i, .reset_n_i,
  .mode_write_transfer_i, .operand_compute_transfer_i, .opnd_i, .stall_o, .result_o,
  .flags_o, .mode_o);
`default_nettype wire

// *** verif/mdc_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mdc_core_model (
  // from coprocessor
  input wire logic clk_i,
  input wire logic stall_i,
  input wire logic [15:0] result_i,
  // transfers: mode write, compute, initial value
  output logic [2:0] xfer_o,
  output var mdc_pkg::mdc_opnd_t opnd_o
);
  import mdc_pkg::*;
  initial begin
    xfer_o = 3'h0;
    opnd_o = 32'h0000_0000;
  end
  // one strobe pulse, then wait out any stall before taking the answer
  task automatic xfer(input logic [2:0] k, input logic [31:0] d, output logic [15:0] r);
    int n;
    n = 0;
    opnd_o = d;
    xfer_o = k;
    @(posedge clk_i);
    #1 xfer_o = 3'h0;
    opnd_o = ~d;
    while (stall_i && n < 30) begin
      @(posedge clk_i);
      #1 n++;
    end
    @(posedge clk_i);
    #1 r = result_i;
  endtask
endmodule
`default_nettype wire
